// [inc/wsr_pkg.sv]
// constants, types and operation codes shared by the word shift and rotate unit
//
// Contract
// - enabled reversible shift moves one bit by bit 12, bit 13 enters, leaver to carry
// - reversible shift leaves register unchanged with condition off or bits 14 and 15 both clear
// - reversible shift with bit 15 set clears whole range and carry
// - reversible carry takes bit 00 of start word or bit 15 of end word
// - reversible shift flags error on split areas or start above end
// - any shift flags error when an indirect data memory operand is missing
// - equal start and end words give a single word register
// - condition off leaves operands and flags untouched for every shift
// - arithmetic left shift fills bit 00 with zero, bit 15 to carry
// - arithmetic right shift fills bit 15 with zero, bit 00 to carry
// - rotate left puts old carry in bit 00, bit 15 to carry
// - rotate right puts old carry in bit 15, bit 00 to carry
// - arithmetic shifts and rotates set equal flag on zero result, else clear
// - left shift and rotates set negative flag when bit 15 becomes one
// - carry is cleared by the cycle end operation of each scan
// - digit left shift moves range four bits left, zero in, top digit lost
// - digit right shift moves range four bits right, zero in, low digit lost
// - digit shifts flag error on split areas or start above end
// - start word is least significant, end word most, words between included
package wsr_pkg;

    // ========================================================================
    // geometry
    localparam int WORD_W = 16;
    localparam int DIGIT_W = 4;
    localparam int ADDR_W = 6;
    localparam int MEM_DEPTH = 64;
    localparam int AREA_LSB = 4;          // upper address bits name the data area

    // ========================================================================
    // control word of the reversible shift
    localparam int CTRL_DIR_BIT = 12;
    localparam int CTRL_FILL_BIT = 13;
    localparam int CTRL_ENABLE_BIT = 14;
    localparam int CTRL_CLEAR_BIT = 15;

    // ========================================================================
    // reset values and address step
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 6'h01;
    localparam logic [DIGIT_W-1:0] LINK_ZERO = 4'h0;

    // ========================================================================
    // operation codes, codes 4'hc to 4'hf are illegal and ignored
    typedef enum logic [3:0] {
        load_word_op = 4'h0,
        fetch_word_op = 4'h1,
        reversible_shift_op = 4'h2,
        arith_left_shift_op = 4'h3,
        arith_right_shift_op = 4'h4,
        rotate_left_op = 4'h5,
        rotate_right_op = 4'h6,
        digit_left_shift_op = 4'h7,
        digit_right_shift_op = 4'h8,
        set_carry_op = 4'h9,
        clear_carry_op = 4'ha,
        cycle_end_op = 4'hb
    } wsr_op_type;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_read = 2'b01,
        st_write = 2'b10,
        st_clear = 2'b11
    } wsr_state_type;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic valid;
        wsr_op_type op;
        logic exec_cond;
        logic ind_fault;
        logic [WORD_W-1:0] ctrl_word;
        logic [ADDR_W-1:0] start_word;
        logic [ADDR_W-1:0] end_word;
        logic [WORD_W-1:0] load_data;
    } wsr_cmd_type;

    typedef struct packed {
        logic carry_flag;
        logic error_flag;
        logic equal_flag;
        logic negative_flag;
    } wsr_flags_type;

    localparam wsr_flags_type FLAGS_RESET = 4'h0;

endpackage : wsr_pkg

// [logic/wsr_word_mem.sv]
// word store of the shift unit, single port with registered read data
`timescale 1ns/100ps
module wsr_word_mem (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic we_in,
    input wire logic [wsr_pkg::ADDR_W-1:0] addr_in,
    input wire logic [wsr_pkg::WORD_W-1:0] wdata_in,
    output logic [wsr_pkg::WORD_W-1:0] rdata_out
);

    // ========================================================================
    // storage, no reset so it maps onto block memory
    logic [wsr_pkg::WORD_W-1:0] mem_ff [wsr_pkg::MEM_DEPTH];
    logic [wsr_pkg::WORD_W-1:0] rdata_ff;

    // write port, frozen while the clock enable is low
    always_ff @(posedge core_clk_in) begin
        if (ce_in && we_in) begin
            mem_ff[addr_in] <= wdata_in;
        end
    end

    // read register, reads old data on a write to the same word
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= wsr_pkg::WORD_ZERO;
        end else if (ce_in) begin
            rdata_ff <= mem_ff[addr_in];
        end
    end

    assign rdata_out = rdata_ff;

endmodule : wsr_word_mem

// [logic/wsr_word_shift_rotate_unit.sv]
// word shift and rotate unit: sequencer command port, word store, flags
`timescale 1ns/100ps
module wsr_word_shift_rotate_unit (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire wsr_pkg::wsr_cmd_type cmd_in,
    output logic ready_out,
    output logic done_out,
    output logic [wsr_pkg::WORD_W-1:0] fetch_word_out,
    output wsr_pkg::wsr_flags_type flags_out
);

    // ========================================================================
    // reset release
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;

    // two stage release so every flop leaves reset on the same edge
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // ========================================================================
    // declarations
    wsr_pkg::wsr_state_type state_ff;
    wsr_pkg::wsr_op_type op_ff;
    wsr_pkg::wsr_flags_type flags_ff;
    logic ready_ff;
    logic done_ff;
    logic [wsr_pkg::WORD_W-1:0] fetch_ff;
    logic [wsr_pkg::ADDR_W-1:0] cur_ff;
    logic [wsr_pkg::ADDR_W-1:0] lo_ff;
    logic [wsr_pkg::ADDR_W-1:0] hi_ff;
    logic [wsr_pkg::DIGIT_W-1:0] link_ff;
    logic left_ff;
    logic digit_ff;
    logic accept;
    logic is_shift;
    logic is_range;
    logic is_left;
    logic range_bad;
    logic fault;
    logic start_walk;
    logic start_clear;
    logic last_word;
    logic mem_we;
    logic [wsr_pkg::ADDR_W-1:0] mem_addr;
    logic [wsr_pkg::WORD_W-1:0] mem_wdata;
    logic [wsr_pkg::WORD_W-1:0] rdata;
    logic [wsr_pkg::WORD_W-1:0] nxt_word;
    logic [wsr_pkg::DIGIT_W-1:0] out_link;
    logic [wsr_pkg::DIGIT_W-1:0] init_link;

    // ========================================================================
    // command decode, only looked at while idle
    assign accept = ce_in && ready_ff && cmd_in.valid;

    always_comb begin
        is_shift = 1'b0;
        is_range = 1'b0;
        is_left = 1'b0;
        init_link = wsr_pkg::LINK_ZERO;
        unique case (cmd_in.op)
            wsr_pkg::reversible_shift_op: begin
                is_shift = 1'b1;
                is_range = 1'b1;
                is_left = cmd_in.ctrl_word[wsr_pkg::CTRL_DIR_BIT];
                init_link = {3'h0, cmd_in.ctrl_word[wsr_pkg::CTRL_FILL_BIT]};
            end
            wsr_pkg::arith_left_shift_op: begin
                is_shift = 1'b1;
                is_left = 1'b1;
            end
            wsr_pkg::arith_right_shift_op: begin
                is_shift = 1'b1;
            end
            wsr_pkg::rotate_left_op: begin
                is_shift = 1'b1;
                is_left = 1'b1;
                init_link = {3'h0, flags_ff.carry_flag};
            end
            wsr_pkg::rotate_right_op: begin
                is_shift = 1'b1;
                init_link = {3'h0, flags_ff.carry_flag};
            end
            wsr_pkg::digit_left_shift_op: begin
                is_shift = 1'b1;
                is_range = 1'b1;
                is_left = 1'b1;
            end
            wsr_pkg::digit_right_shift_op: begin
                is_shift = 1'b1;
                is_range = 1'b1;
            end
            default: begin
                is_shift = 1'b0;
            end
        endcase
    end

    // a range must stay inside one data area and run upward
    assign range_bad = (cmd_in.start_word[wsr_pkg::ADDR_W-1:wsr_pkg::AREA_LSB] !=
                        cmd_in.end_word[wsr_pkg::ADDR_W-1:wsr_pkg::AREA_LSB]) ||
                       (cmd_in.start_word > cmd_in.end_word);
    assign fault = cmd_in.ind_fault || (is_range && range_bad);

    // a faulted shift never touches memory
    assign start_clear = accept && cmd_in.exec_cond && !fault &&
                         (cmd_in.op == wsr_pkg::reversible_shift_op) &&
                         cmd_in.ctrl_word[wsr_pkg::CTRL_CLEAR_BIT];
    assign start_walk = accept && cmd_in.exec_cond && is_shift && !fault && !start_clear &&
                        ((cmd_in.op != wsr_pkg::reversible_shift_op) ||
                         cmd_in.ctrl_word[wsr_pkg::CTRL_ENABLE_BIT]);

    // ========================================================================
    // one bit or one digit step on the word just read
    logic [wsr_pkg::WORD_W-1:0] fetch_word_raw;
    assign rdata = fetch_word_raw;

    always_comb begin
        nxt_word = wsr_pkg::WORD_ZERO;
        out_link = wsr_pkg::LINK_ZERO;
        if (digit_ff && left_ff) begin
            nxt_word = {rdata[11:0], link_ff};
            out_link = rdata[15:12];
        end else if (digit_ff) begin
            nxt_word = {link_ff, rdata[15:4]};
            out_link = rdata[3:0];
        end else if (left_ff) begin
            nxt_word = {rdata[14:0], link_ff[0]};
            out_link = {3'h0, rdata[15]};
        end else begin
            nxt_word = {link_ff[0], rdata[15:1]};
            out_link = {3'h0, rdata[0]};
        end
    end

    // left walks start to end, right walks end to start, so the start word is the low end
    assign last_word = left_ff ? (cur_ff == hi_ff) : (cur_ff == lo_ff);

    // ========================================================================
    // memory port steering
    always_comb begin
        mem_we = 1'b0;
        mem_addr = cur_ff;
        mem_wdata = nxt_word;
        if (state_ff == wsr_pkg::st_idle) begin
            mem_addr = cmd_in.start_word;
            mem_wdata = cmd_in.load_data;
            mem_we = accept && (cmd_in.op == wsr_pkg::load_word_op);
        end else if (state_ff == wsr_pkg::st_clear) begin
            mem_we = 1'b1;
            mem_wdata = wsr_pkg::WORD_ZERO;
        end else if (state_ff == wsr_pkg::st_write) begin
            mem_we = (op_ff != wsr_pkg::fetch_word_op);
        end
    end

    wsr_word_mem u_mem (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(fetch_word_raw)
    );

    // ========================================================================
    // sequencer: two cycles per word, one per word when clearing
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= wsr_pkg::st_idle;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce_in) begin
            done_ff <= 1'b0;
            unique case (state_ff)
                wsr_pkg::st_idle: begin
                    ready_ff <= 1'b1;
                    if (start_clear) begin
                        state_ff <= wsr_pkg::st_clear;
                        ready_ff <= 1'b0;
                    end else if (start_walk || (accept && cmd_in.op == wsr_pkg::fetch_word_op)) begin
                        state_ff <= wsr_pkg::st_read;
                        ready_ff <= 1'b0;
                    end else if (accept) begin
                        done_ff <= 1'b1;
                    end
                end
                wsr_pkg::st_read: begin
                    state_ff <= wsr_pkg::st_write;
                end
                wsr_pkg::st_write: begin
                    if (last_word || op_ff == wsr_pkg::fetch_word_op) begin
                        state_ff <= wsr_pkg::st_idle;
                        ready_ff <= 1'b1;
                        done_ff <= 1'b1;
                    end else begin
                        state_ff <= wsr_pkg::st_read;
                    end
                end
                wsr_pkg::st_clear: begin
                    if (cur_ff == hi_ff) begin
                        state_ff <= wsr_pkg::st_idle;
                        ready_ff <= 1'b1;
                        done_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // operand latch and word pointer
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            op_ff <= wsr_pkg::load_word_op;
            cur_ff <= wsr_pkg::ADDR_ZERO;
            lo_ff <= wsr_pkg::ADDR_ZERO;
            hi_ff <= wsr_pkg::ADDR_ZERO;
            link_ff <= wsr_pkg::LINK_ZERO;
            left_ff <= 1'b0;
            digit_ff <= 1'b0;
        end else if (ce_in) begin
            if (accept) begin
                op_ff <= cmd_in.op;
                lo_ff <= cmd_in.start_word;
                // single word operations reuse the start word as both ends
                hi_ff <= is_range ? cmd_in.end_word : cmd_in.start_word;
                cur_ff <= (is_range && !is_left && !start_clear) ? cmd_in.end_word : cmd_in.start_word;
                link_ff <= init_link;
                left_ff <= is_left;
                digit_ff <= (cmd_in.op == wsr_pkg::digit_left_shift_op) ||
                            (cmd_in.op == wsr_pkg::digit_right_shift_op);
            end else if (state_ff == wsr_pkg::st_write) begin
                link_ff <= out_link; // carries the lost bits into the next word
                cur_ff <= left_ff ? cur_ff + wsr_pkg::ADDR_STEP : cur_ff - wsr_pkg::ADDR_STEP;
            end else if (state_ff == wsr_pkg::st_clear) begin
                cur_ff <= cur_ff + wsr_pkg::ADDR_STEP;
            end
        end
    end

    // fetched word for the sequencer
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            fetch_ff <= wsr_pkg::WORD_ZERO;
        end else if (ce_in && state_ff == wsr_pkg::st_write && op_ff == wsr_pkg::fetch_word_op) begin
            fetch_ff <= rdata;
        end
    end

    // ========================================================================
    // flags: condition-off shifts fall through every branch and keep them
    logic word_op;
    logic neg_op;
    assign word_op = (op_ff == wsr_pkg::arith_left_shift_op) || (op_ff == wsr_pkg::arith_right_shift_op) ||
                     (op_ff == wsr_pkg::rotate_left_op) || (op_ff == wsr_pkg::rotate_right_op);
    assign neg_op = word_op && (op_ff != wsr_pkg::arith_right_shift_op);

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= wsr_pkg::FLAGS_RESET;
        end else if (ce_in) begin
            if (accept && cmd_in.op == wsr_pkg::cycle_end_op) begin
                flags_ff.carry_flag <= 1'b0;
            end else if (accept && cmd_in.exec_cond && cmd_in.op == wsr_pkg::set_carry_op) begin
                flags_ff.carry_flag <= 1'b1;
            end else if (accept && cmd_in.exec_cond && cmd_in.op == wsr_pkg::clear_carry_op) begin
                flags_ff.carry_flag <= 1'b0;
            end else if (accept && cmd_in.exec_cond && is_shift) begin
                flags_ff.error_flag <= fault;
                if (start_clear) begin
                    flags_ff.carry_flag <= 1'b0;
                end
            end else if (state_ff == wsr_pkg::st_write && last_word && op_ff != wsr_pkg::fetch_word_op) begin
                if (!digit_ff) begin
                    flags_ff.carry_flag <= out_link[0];
                end
                if (word_op) begin
                    flags_ff.equal_flag <= (nxt_word == wsr_pkg::WORD_ZERO);
                end
                if (neg_op) begin
                    flags_ff.negative_flag <= nxt_word[15];
                end
            end
        end
    end

    assign ready_out = ready_ff;
    assign done_out = done_ff;
    assign fetch_word_out = fetch_ff;
    assign flags_out = flags_ff;

    // ========================================================================
    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    property p_cond_off;
        accept && is_shift && !cmd_in.exec_cond |=> $stable(flags_ff) && ready_ff && done_ff;
    endproperty
    a_cond_off: assert property (p_cond_off) else $error("flags moved on condition off");

    property p_cycle_end;
        accept && cmd_in.op == wsr_pkg::cycle_end_op |=> !flags_ff.carry_flag;
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("carry kept past cycle end");

    property p_range_fault;
        accept && cmd_in.exec_cond && is_range && range_bad |=> flags_ff.error_flag && ready_ff;
    endproperty
    a_range_fault: assert property (p_range_fault) else $error("bad range not flagged");

    property p_ind_fault;
        accept && cmd_in.exec_cond && is_shift && cmd_in.ind_fault |=> flags_ff.error_flag;
    endproperty
    a_ind_fault: assert property (p_ind_fault) else $error("missing operand not flagged");

    property p_write_in_range;
        mem_we && state_ff != wsr_pkg::st_idle |-> cur_ff >= lo_ff && cur_ff <= hi_ff;
    endproperty
    a_write_in_range: assert property (p_write_in_range) else $error("write outside range");

    property p_left_zero_fill;
        state_ff == wsr_pkg::st_write && op_ff == wsr_pkg::arith_left_shift_op |->
            mem_wdata == {rdata[14:0], 1'b0};
    endproperty
    a_left_zero_fill: assert property (p_left_zero_fill) else $error("left shift value wrong");

    property p_right_zero_fill;
        state_ff == wsr_pkg::st_write && op_ff == wsr_pkg::arith_right_shift_op |->
            mem_wdata == {1'b0, rdata[15:1]};
    endproperty
    a_right_zero_fill: assert property (p_right_zero_fill) else $error("right shift value wrong");

    property p_clear_range;
        start_clear |=> !flags_ff.carry_flag && state_ff == wsr_pkg::st_clear && mem_wdata == wsr_pkg::WORD_ZERO;
    endproperty
    a_clear_range: assert property (p_clear_range) else $error("clear did not start");

    property p_equal;
        ce_in && state_ff == wsr_pkg::st_write && word_op |=> flags_ff.equal_flag == ($past(nxt_word) == 16'h0000);
    endproperty
    a_equal: assert property (p_equal) else $error("equal flag wrong");

    property p_negative;
        ce_in && state_ff == wsr_pkg::st_write && neg_op |=> flags_ff.negative_flag == $past(nxt_word[15]);
    endproperty
    a_negative: assert property (p_negative) else $error("negative flag wrong");

    c_digit_left: cover property (done_ff && op_ff == wsr_pkg::digit_left_shift_op && hi_ff != lo_ff);
    c_reversible: cover property (done_ff && op_ff == wsr_pkg::reversible_shift_op);
    c_rotate: cover property (done_ff && op_ff == wsr_pkg::rotate_right_op && flags_ff.carry_flag);
    c_fault: cover property (accept && fault && cmd_in.exec_cond);

endmodule : wsr_word_shift_rotate_unit

// [verification/wsr_seq_model.sv]
// sequencer model that hands one command at a time to the shift unit
`timescale 1ns/100ps
module wsr_seq_model (
    input wire logic core_clk_in,
    input wire logic ready_in,
    output logic ce_out,
    output wsr_pkg::wsr_cmd_type cmd_out
);
    // ========================================================================
    // command issue
    initial begin
        cmd_out = '0;
        ce_out = 1'b1;
    end
    // the sequencer stalls the unit now and then; a command is only taken on an enabled edge
    // holds the command until the edge that takes it; released fields are scrambled so stale values never match
    task automatic issue(input wsr_pkg::wsr_cmd_type cmd);
        @(posedge core_clk_in);
        #1;
        cmd_out = cmd;
        ce_out = ($urandom % 4) != 0;
        while (ready_in !== 1'b1 || ce_out !== 1'b1) begin
            @(posedge core_clk_in);
            #1;
            ce_out = ($urandom % 4) != 0;
        end
        @(posedge core_clk_in);
        #1;
        cmd_out = {1'b0, ~cmd[$bits(cmd)-2:0]};
    endtask : issue
endmodule : wsr_seq_model

// [verification/wsr_word_shift_rotate_unit_tb_top.sv]
// self-checking bench of the word shift and rotate unit
`timescale 1ns/100ps
module wsr_word_shift_rotate_unit_tb_top;
    typedef struct {logic [3:0] f; logic [15:0] w; bit fw;} wsr_note_type;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ready, done;
    logic ce;
    logic ce_prev = 1'b1;
    logic [15:0] ctls [6] = '{16'h7000, 16'h4000, 16'h6000, 16'h5000, 16'h3000, 16'hc000};
    logic [15:0] fword;
    wsr_pkg::wsr_flags_type flags;
    wsr_pkg::wsr_cmd_type cmd;
    wsr_note_type notes[$];
    logic [15:0] rmem [64];
    logic rc = 1'b0, re = 1'b0, rz = 1'b0, rn = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    // ========================================================================
    // clock, design and sequencer
    always #12.5 core_clk = ~core_clk;
    wsr_word_shift_rotate_unit DUT (.core_clk_in(core_clk), .nrst_in(nrst), .ce_in(ce), .cmd_in(cmd),
        .ready_out(ready), .done_out(done), .fetch_word_out(fword), .flags_out(flags));
    wsr_seq_model seq (.core_clk_in(core_clk), .ready_in(ready), .ce_out(ce), .cmd_out(cmd));
    // ========================================================================
    // checking
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // results come back in issue order; done is new only if the edge that raised it was enabled
    always @(negedge core_clk) begin : watch
        wsr_note_type n;
        if (done === 1'b1 && ce_prev === 1'b1) begin
            if (notes.size() == 0) begin
                cmp("spare done", 16'h0000, 16'h0001);
            end else begin
                n = notes.pop_front();
                cmp("flags", 16'(n.f), 16'(flags));
                if (n.fw) cmp("word", n.w, fword);
            end
        end
        ce_prev = ce;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // ========================================================================
    // reference model, then issue; left range ops walk start (low) to end (high), right ones end to start
    task automatic run(input wsr_pkg::wsr_op_type op, input logic cnd, input logic flt, input logic [15:0] ctl,
                       input logic [5:0] st, input logic [5:0] en);
        wsr_note_type n;
        logic [15:0] w, t, cin;
        logic lft, bad, rv;
        int k, a;
        w = rmem[st];
        rv = (op == wsr_pkg::reversible_shift_op);
        bad = flt || ((rv || op > wsr_pkg::rotate_right_op) && (st[5:4] != en[5:4] || st > en));
        n.fw = (op == wsr_pkg::fetch_word_op);
        n.w = w;
        if (op == wsr_pkg::load_word_op) rmem[st] = ctl;
        if (op == wsr_pkg::cycle_end_op) rc = 1'b0;
        if (cnd && op == wsr_pkg::set_carry_op) rc = 1'b1;
        if (cnd && op == wsr_pkg::clear_carry_op) rc = 1'b0;
        if (cnd && rv | (op > wsr_pkg::reversible_shift_op && op < wsr_pkg::set_carry_op)) begin
            re = bad;
            if (!bad && op < wsr_pkg::digit_left_shift_op && !rv) begin
                case (op)
                    wsr_pkg::arith_left_shift_op: {rc, w} = {w, 1'b0};
                    wsr_pkg::arith_right_shift_op: {w, rc} = {1'b0, w};
                    wsr_pkg::rotate_left_op: {rc, w} = {w, rc};
                    default: {w, rc} = {rc, w};
                endcase
                rmem[st] = w;
                rz = (w == 16'h0000);
                if (op != wsr_pkg::arith_right_shift_op) rn = w[15];
            end else if (!bad && rv && ctl[15]) begin
                for (a = st; a <= en; a++) rmem[a] = 16'h0000;
                rc = 1'b0;
            end else if (!bad && (!rv || ctl[14])) begin
                k = rv ? 1 : 4;
                lft = (op == wsr_pkg::digit_left_shift_op) || (rv && ctl[12]);
                cin = lft ? {15'h0000, rv & ctl[13]} : {rv & ctl[13], 15'h0000};
                for (int i = 0; i <= en - st; i++) begin
                    a = lft ? st + i : en - i;
                    t = rmem[a];
                    rmem[a] = lft ? ((t << k) | cin) : ((t >> k) | cin);
                    cin = lft ? (t >> (16 - k)) : (t << (16 - k));
                end
                if (rv) rc = lft ? cin[0] : cin[15];
            end
        end
        n.f = {rc, re, rz, rn};
        notes.push_back(n);
        seq.issue({1'b1, op, cnd, flt, ctl, st, en, ctl});
    endtask : run
    task automatic look(input logic [5:0] a, input logic [5:0] b);
        run(wsr_pkg::fetch_word_op, 1'b1, 1'b0, 16'h0000, a, a);
        run(wsr_pkg::fetch_word_op, 1'b1, 1'b0, 16'h0000, b, b);
    endtask : look
    // ========================================================================
    // main sequence
    initial begin
        logic [5:0] st, en;
        void'($urandom(32'ha599d135));
        repeat (8) @(posedge core_clk);
        #1 nrst = 1'b1;
        for (int a = 0; a < 64; a++) run(wsr_pkg::load_word_op, 1'b1, 1'b0, 16'($urandom), 6'(a), 6'(a));
        foreach (ctls[i]) begin
            run(wsr_pkg::reversible_shift_op, 1'b1, 1'b0, ctls[i], 6'h21, 6'h23);
            look(6'h21, 6'h23);
        end
        run(wsr_pkg::reversible_shift_op, 1'b1, 1'b0, 16'h5000, 6'h05, 6'h05);
        run(wsr_pkg::reversible_shift_op, 1'b1, 1'b0, 16'h4000, 6'h12, 6'h11);
        run(wsr_pkg::digit_left_shift_op, 1'b1, 1'b0, 16'h0000, 6'h0e, 6'h11);
        run(wsr_pkg::arith_left_shift_op, 1'b1, 1'b1, 16'h0000, 6'h05, 6'h05);
        run(wsr_pkg::rotate_left_op, 1'b0, 1'b0, 16'h0000, 6'h05, 6'h05);
        run(wsr_pkg::set_carry_op, 1'b1, 1'b0, 16'h0000, 6'h05, 6'h05);
        run(wsr_pkg::cycle_end_op, 1'b0, 1'b0, 16'h0000, 6'h05, 6'h05);
        for (int o = 3; o <= 8; o++) begin
            run(wsr_pkg::wsr_op_type'(4'(o)), 1'b1, 1'b0, 16'h0000, 6'h30, 6'h32);
            look(6'h30, 6'h32);
        end
        for (int i = 0; i < 200; i++) begin
            st = 6'($urandom);
            en = ($urandom % 8 == 0) ? st - 6'h01 : st + 6'($urandom % 4);
            run(wsr_pkg::wsr_op_type'(4'(2 + $urandom % 14)), ($urandom % 8) != 0, ($urandom % 16) == 0,
                16'($urandom), st, en);
            look(st, en);
        end
        repeat (10) @(posedge core_clk);
        cmp("pending notes", 16'h0000, 16'(notes.size()));
        cmp("ready", 16'h0001, 16'(ready));
        wrap_up();
    end
    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        wrap_up();
    end
endmodule : wsr_word_shift_rotate_unit_tb_top
